/* design/papr_map.svh */
// constants for the print area and relative position command parser
`ifndef PAPR_MAP_SVH
`define PAPR_MAP_SVH
// ---------------------------------------------------------------
// command bytes
// ---------------------------------------------------------------
`define PAPR_ESC 8'h1B
`define PAPR_SET_AREA 8'h57
`define PAPR_REL_POS 8'h5C
// ---------------------------------------------------------------
// argument counts (index of last argument byte)
// ---------------------------------------------------------------
`define PAPR_AREA_LAST 3'h7
`define PAPR_REL_LAST 3'h1
// ---------------------------------------------------------------
// printable limits in dots at unit pitch
// ---------------------------------------------------------------
`define PAPR_HLIM 25'h0000240
`define PAPR_VLIM 25'h0000300
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define PAPR_RST_POS 24'h000000
`define PAPR_RST_AREA 24'h000000
`define PAPR_RST_WIDTH 24'h000240
`define PAPR_RST_HEIGHT 24'h000300
`define PAPR_ZERO_IDX 3'h0
`endif

/* design/papr_pkg.sv */
// shared types of the print area and relative position parser
package papr_pkg;
  typedef enum logic [1:0] {
    PAPR_IDLE,
    PAPR_CODE,
    PAPR_ARGS,
    PAPR_EXEC
  } papr_state_e;
  typedef logic [7:0] papr_byte_t;
endpackage

/* design/papr_stream_if.sv */
// byte stream carrier between the buffer and the parser
`timescale 1ns/100ps
interface papr_stream_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* design/papr_buf.sv */
// two-entry byte buffer between host stream and parser
`timescale 1ns/100ps
module papr_buf
  import papr_pkg::*;
#(
  parameter int DW = 8
) (
  input wire logic sys_clk, // 250 MHz clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic in_valid, // host byte valid
  input wire logic [DW-1:0] in_data, // host byte
  output logic in_ready, // buffer has room
  papr_stream_if.src out // toward the parser
);
  logic [DW-1:0] ent [2];
  logic [DW-1:0] next_ent [2];
  logic [1:0] cnt;
  logic [1:0] next_cnt;
  logic next_in_ready;
  logic push;
  logic pop;

  assign out.valid = (cnt != 2'h0);
  assign out.data = ent[0];

  always_comb begin
    push = in_valid && in_ready;
    pop = out.valid && out.ready;
    next_ent = ent;
    next_cnt = cnt;
    if (pop) begin
      next_ent[0] = ent[1];
      next_cnt = next_cnt - 2'h1;
    end
    if (push) begin
      next_ent[next_cnt[0]] = in_data;
      next_cnt = next_cnt + 2'h1;
    end
    // ready is registered so the host sees a clean flop output
    next_in_ready = (next_cnt != 2'h2);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt <= 2'h0;
      in_ready <= 1'b0;
      ent[0] <= '0;
      ent[1] <= '0;
    end else begin
      cnt <= next_cnt;
      in_ready <= next_in_ready;
      ent <= next_ent;
    end
  end

  no_overfill_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cnt == 2'h2 |-> !in_ready) else $error("buffer full but ready high");
endmodule

/* design/papr_top.sv */
// page-mode print area and relative print position command parser
// ---------------------------------------------------------------
// Behaviour
// - the set-area command takes x, y, width and height as little-endian pairs scaled by pitch.
// - a width that overruns the printable area is cut to the horizontal limit minus x, or to zero when x is at or past that limit.
// - a height that overruns the printable area is cut to the vertical limit minus y, or to zero when y is at or past that limit.
// - the relative move sets the position to the current one plus offset times pitch.
// - a relative move that leaves the print range is dropped and the position kept.
// ---------------------------------------------------------------
`timescale 1ns/100ps
`include "papr_map.svh"
module papr_top
  import papr_pkg::*;
#(
  parameter int PW = 8, // width of the basic calculated pitch
  parameter int DW = 24 // width of scaled dot values
) (
  input wire logic sys_clk, // 250 MHz clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic in_valid, // host command byte valid
  input wire logic [7:0] in_byte, // host command byte
  output logic in_ready, // byte accepted when high with valid
  input wire logic [PW-1:0] pitch, // basic calculated pitch
  output logic [DW-1:0] area_x, // horizontal start in dots
  output logic [DW-1:0] area_y, // vertical start in dots
  output logic [DW-1:0] area_width, // stored width in dots
  output logic [DW-1:0] area_height, // stored height in dots
  output logic [DW-1:0] print_pos, // next print start in dots
  output logic area_set, // pulse: area updated
  output logic pos_moved, // pulse: relative move applied
  output logic pos_ignored // pulse: relative move dropped
);
  papr_stream_if bus ();

  papr_buf #(.DW(8)) u_buf (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(in_valid),
    .in_data(in_byte),
    .in_ready(in_ready),
    .out(bus.src)
  );

  // ---------------------------------------------------------------
  // parser state
  // ---------------------------------------------------------------
  papr_state_e state, next_state;
  logic cmd_area, next_cmd_area;
  logic [2:0] idx, next_idx;
  papr_byte_t arg [8];
  papr_byte_t next_arg [8];
  logic [DW-1:0] next_area_x, next_area_y, next_area_width, next_area_height;
  logic [DW-1:0] next_print_pos;
  logic next_area_set, next_pos_moved, next_pos_ignored;
  logic take;
  logic [DW-1:0] sx, sy, sw, sh, soff;
  logic [DW:0] rel_sum;
  logic rel_over;

  // the parser stalls the buffer while it executes, so bytes queue up
  assign bus.ready = (state != PAPR_EXEC);
  assign take = bus.valid && bus.ready;

  // ---------------------------------------------------------------
  // scaling and range checks
  // ---------------------------------------------------------------
  always_comb begin
    sx = DW'({arg[1], arg[0]} * pitch);
    sy = DW'({arg[3], arg[2]} * pitch);
    sw = DW'({arg[5], arg[4]} * pitch);
    sh = DW'({arg[7], arg[6]} * pitch);
    soff = DW'({arg[1], arg[0]} * pitch);
    rel_sum = {1'b0, print_pos} + {1'b0, soff};
    // print range is the horizontal printable extent
    rel_over = (rel_sum >= `PAPR_HLIM);
  end

  // ---------------------------------------------------------------
  // next values
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_cmd_area = cmd_area;
    next_idx = idx;
    next_arg = arg;
    next_area_x = area_x;
    next_area_y = area_y;
    next_area_width = area_width;
    next_area_height = area_height;
    next_print_pos = print_pos;
    next_area_set = 1'b0;
    next_pos_moved = 1'b0;
    next_pos_ignored = 1'b0;
    case (state)
      PAPR_IDLE: begin
        if (take && bus.data == `PAPR_ESC) begin
          next_state = PAPR_CODE;
        end
      end
      PAPR_CODE: begin
        if (take) begin
          next_idx = `PAPR_ZERO_IDX;
          if (bus.data == `PAPR_SET_AREA) begin
            next_cmd_area = 1'b1;
            next_state = PAPR_ARGS;
          end else if (bus.data == `PAPR_REL_POS) begin
            next_cmd_area = 1'b0;
            next_state = PAPR_ARGS;
          end else begin
            // unknown codes belong to other blocks; resync on next escape
            next_state = PAPR_IDLE;
          end
        end
      end
      PAPR_ARGS: begin
        if (take) begin
          next_arg[idx] = bus.data;
          next_idx = idx + 3'h1;
          if (idx == (cmd_area ? `PAPR_AREA_LAST : `PAPR_REL_LAST)) begin
            next_state = PAPR_EXEC;
          end
        end
      end
      PAPR_EXEC: begin
        next_state = PAPR_IDLE;
        if (cmd_area) begin
          next_area_x = sx;
          next_area_y = sy;
          next_area_width = sw;
          next_area_height = sh;
          if ({1'b0, sx} + {1'b0, sw} > `PAPR_HLIM) begin
            next_area_width = (sx >= DW'(`PAPR_HLIM)) ? '0 : DW'(`PAPR_HLIM) - sx;
          end
          if ({1'b0, sy} + {1'b0, sh} > `PAPR_VLIM) begin
            next_area_height = (sy >= DW'(`PAPR_VLIM)) ? '0 : DW'(`PAPR_VLIM) - sy;
          end
          next_area_set = 1'b1;
        end else if (rel_over) begin
          next_pos_ignored = 1'b1;
        end else begin
          next_print_pos = rel_sum[DW-1:0];
          next_pos_moved = 1'b1;
        end
      end
      default: begin
        next_state = PAPR_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= PAPR_IDLE;
      cmd_area <= 1'b0;
      idx <= `PAPR_ZERO_IDX;
      for (int i = 0; i < 8; i++) begin
        arg[i] <= '0;
      end
      area_x <= `PAPR_RST_AREA;
      area_y <= `PAPR_RST_AREA;
      area_width <= `PAPR_RST_WIDTH;
      area_height <= `PAPR_RST_HEIGHT;
      print_pos <= `PAPR_RST_POS;
      area_set <= 1'b0;
      pos_moved <= 1'b0;
      pos_ignored <= 1'b0;
    end else begin
      state <= next_state;
      cmd_area <= next_cmd_area;
      idx <= next_idx;
      arg <= next_arg;
      area_x <= next_area_x;
      area_y <= next_area_y;
      area_width <= next_area_width;
      area_height <= next_area_height;
      print_pos <= next_print_pos;
      area_set <= next_area_set;
      pos_moved <= next_pos_moved;
      pos_ignored <= next_pos_ignored;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  area_scale_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == PAPR_EXEC && cmd_area |=> area_set && area_x == $past(sx) && area_y == $past(sy))
    else $error("area start not scaled from arguments");
  width_clip_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    area_set && area_x < DW'(`PAPR_HLIM) |-> {1'b0, area_x} + {1'b0, area_width} <= `PAPR_HLIM)
    else $error("area width overruns horizontal limit");
  height_clip_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    area_set && area_y < DW'(`PAPR_VLIM) |-> {1'b0, area_y} + {1'b0, area_height} <= `PAPR_VLIM)
    else $error("area height overruns vertical limit");
  rel_order_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == PAPR_CODE && take && bus.data == `PAPR_REL_POS
    |=> state == PAPR_ARGS && !cmd_area && idx == `PAPR_ZERO_IDX)
    else $error("relative move did not start argument collection");
  pos_move_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == PAPR_EXEC && !cmd_area && !rel_over
    |=> pos_moved && print_pos == $past(rel_sum[DW-1:0]))
    else $error("relative move not applied");
  pos_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == PAPR_EXEC && !cmd_area && rel_over |=> pos_ignored && $stable(print_pos))
    else $error("out of range move changed position");
  exec_after_args_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == PAPR_EXEC |-> $past(state) == PAPR_ARGS ##1 state == PAPR_IDLE)
    else $error("command acted out of sequence");
  exec_stall_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bus.valid && !bus.ready |=> bus.valid && $stable(bus.data))
    else $error("buffered byte lost while parser stalled");
  area_code_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == PAPR_CODE && take && bus.data == `PAPR_SET_AREA
    |=> state == PAPR_ARGS && cmd_area && idx == `PAPR_ZERO_IDX)
    else $error("area command did not start argument collection");
  width_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == PAPR_EXEC && cmd_area && {1'b0, sx} + {1'b0, sw} <= `PAPR_HLIM
    |=> area_width == $past(sw)) else $error("fitting width was altered");
  height_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == PAPR_EXEC && cmd_area && {1'b0, sy} + {1'b0, sh} <= `PAPR_VLIM
    |=> area_height == $past(sh)) else $error("fitting height was altered");
  code_resync_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == PAPR_CODE && take && bus.data != `PAPR_SET_AREA && bus.data != `PAPR_REL_POS
    |=> state == PAPR_IDLE) else $error("unknown code did not return to idle");
endmodule

/* sim/papr_host.sv */
// host model: sends command bytes to the parser one at a time
`timescale 1ns/100ps
module papr_host (
  input wire logic sys_clk, // bench clock
  input wire logic in_ready, // parser buffer has room
  output logic in_valid, // byte offered
  output logic [7:0] in_byte, // byte value
  output logic hung // a byte was never taken
);
  initial begin
    in_valid = 1'b0;
    in_byte = 8'hA5;
    hung = 1'b0;
  end
  task automatic idle();
    @(negedge sys_clk);
    in_valid = 1'b0;
    in_byte = ~in_byte; // a released line must not look like the last byte
  endtask
  // a byte stays up until taken, so bytes arrive whole and in order
  task automatic send(input logic [7:0] b, input int gap);
    int k;
    logic taken;
    repeat (gap) idle();
    @(negedge sys_clk);
    in_valid = 1'b1;
    in_byte = b;
    taken = 1'b0;
    for (k = 0; k < 100 && !taken; k++) begin
      // ready is a flop: its settled value mid-cycle is what the next edge samples
      taken = (in_ready === 1'b1);
      @(posedge sys_clk);
      if (!taken) @(negedge sys_clk);
    end
    if (!taken) hung = 1'b1;
  endtask
endmodule

/* sim/papr_top_tb.sv */
// self-checking bench for the print area and relative position parser
`timescale 1ns/100ps
module papr_top_tb;
  import papr_pkg::*;
  typedef struct {int kind; logic [23:0] a, b, c, d;} papr_note_s;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic in_valid, in_ready, hung, area_set, pos_moved, pos_ignored;
  logic [7:0] in_byte;
  logic [7:0] pitch = 8'h01;
  logic [23:0] area_x, area_y, area_width, area_height, print_pos;
  int n_fail = 0;
  int checks_done = 0;
  int pos_exp = 0;
  int slow = 0;
  papr_note_s notes[$];
  always #2 sys_clk = ~sys_clk;
  papr_host host (.sys_clk(sys_clk), .in_ready(in_ready), .in_valid(in_valid),
    .in_byte(in_byte), .hung(hung));
  papr_top #(.PW(8), .DW(24)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .in_valid(in_valid),
    .in_byte(in_byte), .in_ready(in_ready), .pitch(pitch), .area_x(area_x),
    .area_y(area_y), .area_width(area_width), .area_height(area_height),
    .print_pos(print_pos), .area_set(area_set), .pos_moved(pos_moved),
    .pos_ignored(pos_ignored));
  // ------------------------------------------------------------
  // checking
  // ------------------------------------------------------------
  task automatic end_of_test();
    $display("checks_done %0d n_fail %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic cmp_area(input papr_note_s n);
    chk("area_x", n.a, area_x);
    chk("area_y", n.b, area_y);
    chk("area_width", n.c, area_width);
    chk("area_height", n.d, area_height);
  endtask
  task automatic cmp_pos(input papr_note_s n);
    chk("print_pos", n.a, print_pos);
  endtask
  // pulses stand one cycle, so the falling edge always sees them settled
  always @(negedge sys_clk) begin
    papr_note_s n;
    if (rst_n && (area_set || pos_moved || pos_ignored)) begin
      n = '{0, 0, 0, 0, 0};
      if (notes.size() > 0) n = notes.pop_front();
      chk("pulses", 24'(n.kind), {21'h0, area_set, pos_ignored, pos_moved});
      if (n.kind == 4) cmp_area(n);
      else cmp_pos(n);
    end
  end
  always @(posedge hung) begin
    n_fail++;
    end_of_test();
  end
  // ------------------------------------------------------------
  // stimulus
  // ------------------------------------------------------------
  task automatic send_cmd(input logic [79:0] seq, input int len);
    for (int i = 0; i < len; i++) host.send(seq[8*i +: 8], $urandom_range(slow, 0));
  endtask
  task automatic area(input logic [15:0] x, y, w, h);
    papr_note_s n;
    int xs, ys, ws, hs;
    xs = x * pitch;
    ys = y * pitch;
    ws = w * pitch;
    hs = h * pitch;
    if (xs + ws > 576) ws = (xs >= 576) ? 0 : 576 - xs;
    if (ys + hs > 768) hs = (ys >= 768) ? 0 : 768 - ys;
    send_cmd({h, w, y, x, 8'h57, 8'h1B}, 10);
    n = '{4, 24'(xs), 24'(ys), 24'(ws), 24'(hs)};
    notes.push_back(n); // note only after the last byte, so an early pulse fails
  endtask
  task automatic rel(input logic [15:0] v);
    papr_note_s n;
    int np;
    np = pos_exp + v * pitch;
    send_cmd({48'h0, v, 8'h5C, 8'h1B}, 4);
    n = '{2, 0, 0, 0, 0};
    if (np < 576) n.kind = 1;
    if (np < 576) pos_exp = np;
    n.a = 24'(pos_exp);
    notes.push_back(n);
  endtask
  task automatic wait_done();
    int k;
    host.idle();
    for (k = 0; k < 200 && notes.size() > 0; k++) @(negedge sys_clk);
    if (notes.size() > 0) begin
      n_fail++;
      $display("[ERR] results expected 0 seen %0d", notes.size());
      end_of_test();
    end else begin
      chk("in_ready", 24'h000001, {23'h0, in_ready});
    end
  endtask
  initial begin
    int i;
    i = $urandom(11739);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    chk("area_width", 24'd576, area_width);
    chk("area_height", 24'd768, area_height);
    chk("print_pos", 24'd0, print_pos);
    chk("in_ready", 24'h000000, {23'h0, in_ready});
    // back to back, so the buffer fills and refuses
    area(16'd10, 16'd20, 16'd100, 16'd200);
    area(16'd500, 16'd0, 16'd100, 16'd768);
    area(16'd0, 16'd700, 16'd576, 16'd69);
    area(16'd600, 16'd800, 16'd1, 16'd1);
    wait_done();
    pitch = 8'h03;
    rel(16'd0);
    rel(16'd100);
    rel(16'd91);
    rel(16'd1);
    rel(16'hFFFF);
    area(16'd190, 16'd255, 16'd3, 16'd1);
    wait_done();
    // stray bytes and an unknown code must give no pulse
    pitch = 8'h01;
    send_cmd({48'h0, 8'h41, 8'h1B, 8'h5C, 8'h00}, 4);
    rel(16'd2);
    wait_done();
    slow = 3;
    for (i = 0; i < 20; i++) begin
      pitch = 8'($urandom_range(4, 1));
      if ($urandom_range(1, 0) == 1)
        area(16'($urandom_range(200, 0)), 16'($urandom_range(300, 0)),
          16'($urandom_range(400, 1)), 16'($urandom_range(400, 1)));
      else
        rel(16'($urandom_range(150, 0)));
      wait_done();
    end
    end_of_test();
  end
endmodule
